// ### src/alias_remap_pkg.sv
// constants and types for the remote alias remap block
package alias_remap_pkg;

	// ==========================================================
	// register offsets
	localparam logic [7:0] OFS_PORT_SEL = 8'h4c;
	localparam logic [7:0] OFS_PHYS0    = 8'h5d;
	localparam logic [7:0] OFS_PHYS5    = 8'h62;
	localparam logic [7:0] OFS_PHYS6    = 8'h63;
	localparam logic [7:0] OFS_PHYS7    = 8'h64;
	localparam logic [7:0] OFS_ALIAS0   = 8'h65;

	// ==========================================================
	// reset values
	localparam logic [7:0] RST_SLOT_REG = 8'h00;
	localparam logic [7:0] RST_PORT_SEL = 8'h00;
	localparam logic [7:0] RDATA_NONE   = 8'h00;

	// ==========================================================
	// field positions
	localparam int ADDR_MSB     = 7;
	localparam int ADDR_LSB     = 1;
	localparam int AUTO_ACK_BIT = 0;
	localparam int PSEL_WEN_MSB = 3;
	localparam int PSEL_WEN_LSB = 0;
	localparam int PSEL_RD_MSB  = 5;
	localparam int PSEL_RD_LSB  = 4;

	// ==========================================================
	// sizes and types
	localparam int NUM_PORTS = 4;
	localparam int NUM_SLOTS = 4;
	localparam int NUM_EXT   = 3;

	typedef logic [6:0] i2c_addr_t;
	typedef logic [1:0] port_t;
	typedef logic [1:0] slot_t;

	// physical slot order inside the block: 0, 5, 6, 7
	typedef enum logic [1:0] {
		SLOT_0 = 2'b00,
		SLOT_5 = 2'b01,
		SLOT_6 = 2'b10,
		SLOT_7 = 2'b11
	} slot_e;

	localparam i2c_addr_t ADDR_DISABLED = 7'h00;

endpackage

// ### src/alias_match.sv
// single alias comparator for one slot of one receive port
`timescale 1ns/10ps
module alias_match
	import alias_remap_pkg::*;
(
	input  wire logic [7:0] alias_reg,
	input  wire i2c_addr_t  addr,
	output logic            hit
);

	// ==========================================================
	// compare
	always_comb begin
		hit = (alias_reg[ADDR_MSB:ADDR_LSB] != ADDR_DISABLED) &&
		      (alias_reg[ADDR_MSB:ADDR_LSB] == addr);
	end

endmodule

// ### src/remote_i2c_alias_remap.sv
// per-port alias decode and physical address remap with register store
// Behaviour
// - physical slots hold 7-bit address, bit0 zero
// - per-port copies chosen by port select register
// - alias slot 0 holds 7-bit alias, detects
// - zero alias disables that slot entirely
// - slot 0 alias remaps via slot 0 physical
// - auto-ack bit acknowledges writes locally
`timescale 1ns/10ps
module remote_i2c_alias_remap
	import alias_remap_pkg::*;
(
	input  wire logic                               clk,
	input  wire logic                               nrst,
	input  wire logic [7:0]                         reg_addr,
	input  wire logic                               reg_wr,
	input  wire logic [7:0]                         reg_wdata,
	input  wire logic                               reg_rd,
	input  wire logic [alias_remap_pkg::NUM_PORTS-1:0][alias_remap_pkg::NUM_EXT-1:0][7:0] alias_ext,
	input  wire logic                               txn_valid,
	input  wire alias_remap_pkg::i2c_addr_t         txn_addr,
	input  wire logic                               txn_rnw,
	output logic [7:0]                              reg_rdata,
	output logic                                    fwd_valid,
	output alias_remap_pkg::port_t                  fwd_port,
	output alias_remap_pkg::i2c_addr_t              fwd_addr,
	output logic                                    fwd_rnw,
	output logic                                    local_ack,
	output logic                                    no_match
);

	// ==========================================================
	// decode helpers
	// returns {hit, slot index} for a physical slot offset
	function automatic logic [2:0] phys_decode(input logic [7:0] a);
		logic [2:0] r;
		r = 3'h0;
		if (a == OFS_PHYS0) begin
			r = {1'b1, SLOT_0};
		end else if (a == OFS_PHYS5) begin
			r = {1'b1, SLOT_5};
		end else if (a == OFS_PHYS6) begin
			r = {1'b1, SLOT_6};
		end else if (a == OFS_PHYS7) begin
			r = {1'b1, SLOT_7};
		end
		return r;
	endfunction

	// per-port write enable bit of the port select register
	function automatic logic port_wr_en(input logic [7:0] psel, input int p);
		return psel[PSEL_WEN_LSB + p];
	endfunction

	// ==========================================================
	// register store
	logic [7:0]      port_sel_q;
	i2c_addr_t       phys_q   [NUM_PORTS][NUM_SLOTS];
	logic [7:0]      alias0_q [NUM_PORTS];
	logic [2:0]      wr_dec;
	logic [2:0]      rd_dec;
	port_t           rd_port;

	assign wr_dec  = phys_decode(reg_addr);
	assign rd_dec  = phys_decode(reg_addr);
	assign rd_port = port_sel_q[PSEL_RD_MSB:PSEL_RD_LSB];

	// ==========================================================
	// write strobes, one per register kind
	logic            wr_psel;
	logic            wr_phys;
	logic            wr_alias;

	always_comb begin
		wr_psel  = 1'b0;
		wr_phys  = 1'b0;
		wr_alias = 1'b0;
		if (reg_addr == OFS_PORT_SEL) begin
			wr_psel = reg_wr;
		end else if (wr_dec[2]) begin
			wr_phys = reg_wr;
		end else if (reg_addr == OFS_ALIAS0) begin
			wr_alias = reg_wr;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			port_sel_q <= RST_PORT_SEL;
		end else if (wr_psel) begin
			port_sel_q <= reg_wdata;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				for (int s = 0; s < NUM_SLOTS; s++) begin
					phys_q[p][s] <= RST_SLOT_REG[ADDR_MSB:ADDR_LSB];
				end
			end
		end else if (wr_phys) begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				if (port_wr_en(port_sel_q, p)) begin
					phys_q[p][wr_dec[1:0]] <= reg_wdata[ADDR_MSB:ADDR_LSB];
				end
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				alias0_q[p] <= RST_SLOT_REG;
			end
		end else if (wr_alias) begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				if (port_wr_en(port_sel_q, p)) begin
					alias0_q[p] <= reg_wdata;
				end
			end
		end
	end

	// ==========================================================
	// register read port, answer one cycle after the strobe
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= RDATA_NONE;
		end else if (reg_rd) begin
			if (reg_addr == OFS_PORT_SEL) begin
				reg_rdata <= port_sel_q;
			end else if (rd_dec[2]) begin
				reg_rdata <= {phys_q[rd_port][rd_dec[1:0]], 1'b0};
			end else if (reg_addr == OFS_ALIAS0) begin
				reg_rdata <= alias0_q[rd_port];
			end else begin
				reg_rdata <= RDATA_NONE;
			end
		end
	end

	// ==========================================================
	// alias comparators, one per port and slot
	logic [NUM_PORTS-1:0][NUM_SLOTS-1:0] hit;

	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
		alias_match u_slot0 (
			.alias_reg (alias0_q[p]),
			.addr      (txn_addr),
			.hit       (hit[p][SLOT_0])
		);
		for (genvar e = 0; e < NUM_EXT; e++) begin : g_ext
			alias_match u_ext (
				.alias_reg (alias_ext[p][e]),
				.addr      (txn_addr),
				.hit       (hit[p][e + 1])
			);
		end
	end

	// ==========================================================
	// pick first hit: lowest port, then slot 0, 5, 6, 7
	logic      any_hit;
	port_t     sel_port;
	slot_t     sel_slot;
	logic      sel_auto;

	always_comb begin
		any_hit  = 1'b0;
		sel_port = '0;
		sel_slot = '0;
		for (int p = NUM_PORTS - 1; p >= 0; p--) begin
			for (int s = NUM_SLOTS - 1; s >= 0; s--) begin
				if (hit[p][s]) begin
					any_hit  = 1'b1;
					sel_port = port_t'(p);
					sel_slot = slot_t'(s);
				end
			end
		end
		if (sel_slot == SLOT_0) begin
			sel_auto = alias0_q[sel_port][AUTO_ACK_BIT];
		end else begin
			sel_auto = alias_ext[sel_port][sel_slot - 2'd1][AUTO_ACK_BIT];
		end
	end

	// ==========================================================
	// forward request, one cycle after the local address
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fwd_valid <= 1'b0;
		end else begin
			fwd_valid <= txn_valid && any_hit;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			no_match <= 1'b0;
		end else begin
			no_match <= txn_valid && !any_hit;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fwd_port <= '0;
			fwd_addr <= ADDR_DISABLED;
			fwd_rnw  <= 1'b0;
		end else if (txn_valid && any_hit) begin
			fwd_port <= sel_port;
			fwd_addr <= phys_q[sel_port][sel_slot];
			fwd_rnw  <= txn_rnw;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			local_ack <= 1'b0;
		end else begin
			local_ack <= txn_valid && any_hit && !txn_rnw && sel_auto;
		end
	end

endmodule

// ### tb/remote_side_model.sv
// far side model counting forwarded transactions
`timescale 1ns/10ps
module remote_side_model
	import alias_remap_pkg::*;
(
	input  wire logic      clk,
	input  wire logic      nrst,
	input  wire logic      fwd_valid,
	input  wire i2c_addr_t fwd_addr,
	output int             seen_cnt,
	output i2c_addr_t      last_addr
);
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			seen_cnt  <= 0;
			last_addr <= 7'h00;
		end else if (fwd_valid) begin
			seen_cnt  <= seen_cnt + 1;
			last_addr <= fwd_addr;
		end
	end
endmodule

// ### tb/alias_remap_chk.sv
// port checker for the alias remap block
`timescale 1ns/10ps
module alias_remap_chk
	import alias_remap_pkg::*;
(
	input wire logic       clk,
	input wire logic       nrst,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_rdata,
	input wire logic       txn_valid,
	input wire i2c_addr_t  txn_addr,
	input wire logic       txn_rnw,
	input wire logic       fwd_valid,
	input wire i2c_addr_t  fwd_addr,
	input wire logic       fwd_rnw,
	input wire logic       local_ack,
	input wire logic       no_match
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence fwd_s;
		txn_valid ##1 fwd_valid;
	endsequence
	ans_one_a: assert property (txn_valid |=> fwd_valid ^ no_match)
		else $error("no single answer");
	no_req_a: assert property (!txn_valid |=> !fwd_valid && !no_match)
		else $error("answer without request");
	ack_wr_a: assert property (local_ack |-> fwd_valid && !fwd_rnw)
		else $error("bad local ack");
	fwd_rnw_a: assert property (fwd_s |-> fwd_rnw == $past(txn_rnw))
		else $error("direction changed");
	zero_alias_a: assert property (txn_valid && txn_addr == 7'h00 |=> no_match)
		else $error("zero alias matched");
	phys_bit0_a: assert property (reg_rd && reg_addr inside {[OFS_PHYS5:OFS_PHYS7]}
		|=> !reg_rdata[0]) else $error("reserved bit set");
	fwd_hold_a: assert property (!fwd_valid |-> $stable(fwd_addr))
		else $error("address moved");
	rd_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved");
endmodule
bind remote_i2c_alias_remap alias_remap_chk i_chk (
	.clk       (clk),
	.nrst      (nrst),
	.reg_rd    (reg_rd),
	.reg_addr  (reg_addr),
	.reg_rdata (reg_rdata),
	.txn_valid (txn_valid),
	.txn_addr  (txn_addr),
	.txn_rnw   (txn_rnw),
	.fwd_valid (fwd_valid),
	.fwd_addr  (fwd_addr),
	.fwd_rnw   (fwd_rnw),
	.local_ack (local_ack),
	.no_match  (no_match)
);

// ### tb/test_remote_i2c_alias_remap.sv
// self-checking bench for the alias remap block
`timescale 1ns/10ps
module test_remote_i2c_alias_remap;
	import alias_remap_pkg::*;
	// ====================
	// signals
	logic                                   clk, nrst, reg_wr, reg_rd, txn_valid, txn_rnw;
	logic [7:0]                             reg_addr, reg_wdata, reg_rdata;
	logic [NUM_PORTS-1:0][NUM_EXT-1:0][7:0] alias_ext;
	i2c_addr_t                              txn_addr, fwd_addr, last_addr;
	port_t                                  fwd_port;
	logic                                   fwd_valid, fwd_rnw, local_ack, no_match;
	int                                     seen_cnt, errors, num_checks;
	remote_i2c_alias_remap i_dut (
		.clk       (clk),
		.nrst      (nrst),
		.reg_addr  (reg_addr),
		.reg_wr    (reg_wr),
		.reg_wdata (reg_wdata),
		.reg_rd    (reg_rd),
		.alias_ext (alias_ext),
		.txn_valid (txn_valid),
		.txn_addr  (txn_addr),
		.txn_rnw   (txn_rnw),
		.reg_rdata (reg_rdata),
		.fwd_valid (fwd_valid),
		.fwd_port  (fwd_port),
		.fwd_addr  (fwd_addr),
		.fwd_rnw   (fwd_rnw),
		.local_ack (local_ack),
		.no_match  (no_match)
	);
	remote_side_model i_rem (
		.clk       (clk),
		.nrst      (nrst),
		.fwd_valid (fwd_valid),
		.fwd_addr  (fwd_addr),
		.seen_cnt  (seen_cnt),
		.last_addr (last_addr)
	);
	// ====================
	// tasks
	task chk(input string n, input logic [7:0] s, e);
		num_checks++;
		if (s !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task wr(input logic [7:0] a, d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk("reg_rdata", reg_rdata, e);
	endtask
	task txn(input i2c_addr_t a, input logic r, v, input i2c_addr_t pa, input port_t p,
		input logic k);
		@(posedge clk);
		txn_valid <= 1'b1;
		txn_addr <= a;
		txn_rnw <= r;
		@(posedge clk);
		txn_valid <= 1'b0;
		#1;
		chk("fwd_valid", fwd_valid, v);
		chk("no_match", no_match, !v);
		chk("local_ack", local_ack, k);
		if (v) begin
			chk("fwd_addr", fwd_addr, pa);
			chk("fwd_port", fwd_port, p);
			chk("fwd_rnw", fwd_rnw, r);
		end
	endtask
	task final_report;
		$display("errors %0d checks %0d", errors, num_checks);
		if (errors == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ====================
	// sequence
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		repeat (5000) @(posedge clk);
		errors++;
		final_report;
	end
	initial begin
		{nrst, reg_wr, reg_rd, txn_valid, txn_rnw, reg_addr, reg_wdata, txn_addr} = '0;
		alias_ext = '0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		rd(OFS_PHYS5, 8'h00);
		rd(OFS_ALIAS0, 8'h00);
		txn(7'h00, 1'b0, 1'b0, 7'h00, 2'h0, 1'b0);
		wr(OFS_PORT_SEL, 8'h0f);
		rd(OFS_PORT_SEL, 8'h0f);
		for (int i = 0; i < 3; i++) begin
			wr(8'(OFS_PHYS5 + i), 8'hff);
			rd(8'(OFS_PHYS5 + i), 8'hfe);
		end
		wr(OFS_PHYS0, 8'h48);
		wr(OFS_ALIAS0, 8'h21);
		rd(OFS_ALIAS0, 8'h21);
		txn(7'h10, 1'b0, 1'b1, 7'h24, 2'h0, 1'b1);
		txn(7'h10, 1'b1, 1'b1, 7'h24, 2'h0, 1'b0);
		txn(7'h33, 1'b0, 1'b0, 7'h00, 2'h0, 1'b0);
		wr(OFS_PORT_SEL, 8'h01);
		wr(OFS_ALIAS0, 8'h01);
		txn(7'h10, 1'b0, 1'b1, 7'h24, 2'h1, 1'b1);
		wr(OFS_PORT_SEL, 8'h10);
		wr(OFS_ALIAS0, 8'h55);
		rd(OFS_ALIAS0, 8'h21);
		wr(OFS_PORT_SEL, 8'h00);
		rd(OFS_ALIAS0, 8'h01);
		@(posedge clk);
		alias_ext[2][0] <= 8'h53;
		txn(7'h29, 1'b0, 1'b1, 7'h7f, 2'h2, 1'b1);
		wr(OFS_PORT_SEL, 8'h0f);
		wr(OFS_PHYS7, 8'h2a);
		@(posedge clk);
		alias_ext[3][2] <= 8'h62;
		txn(7'h31, 1'b0, 1'b1, 7'h15, 2'h3, 1'b0);
		rd(8'h70, 8'h00);
		chk("seen_cnt", 8'(seen_cnt), 8'h05);
		chk("last_addr", 8'(last_addr), 8'h15);
		@(posedge clk);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		rd(OFS_PORT_SEL, 8'h00);
		rd(OFS_PHYS7, 8'h00);
		rd(OFS_ALIAS0, 8'h00);
		txn(7'h10, 1'b0, 1'b0, 7'h00, 2'h0, 1'b0);
		final_report;
	end
endmodule
